//--- dsd_dac_core.sv
// delta-sigma dac core: serial capture, 8x interpolation, 5-level modulator
// assumes: bit clock, sample clock and data come from one source logic;
// I_MCLK is the system clock at 256fs or 384fs of the sample clock
// How it works
// - modulator quantises to five levels through a fourth-order loop filter
// - modulator steps every 8 system clocks: 48fs at 384fs, 32fs at 256fs
// - interpolator only ever sees 20-bit words; 16-bit words get four zeros
// - serial capture accepts 16-bit or 20-bit words
// - input to output latency is 22.625 sample periods
// - stopped sample clock for 65536 bit clocks forces midscale output
// - automatic internal reset ends after 64 sample clock periods
// - after a rate change output is invalid for latency plus two periods
// - four feed coefficients shape the loop, three stabilise feedback
// - constant data for 65536 bit clocks forces midscale, modulator off
// - word length select low means 16-bit, high 20-bit; reset gives 16
module dsd_dac_core
  import dsd_pkg::*;
#(
  parameter int ZERO_COUNT = ZERO_BCLK
)
(
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_SERIAL_BIT_CLOCK_IN,
  input  wire logic              I_SAMPLE_RATE_CLOCK_IN,
  input  wire logic              I_SERIAL_DATA_IN,
  input  wire logic              I_WORD_LENGTH_SELECT,
  input  wire logic              I_ZERO_DETECT_ENABLE,
  input  wire logic              I_RATIO_384,
  output logic [CODE_W-1:0]      O_LEFT_CODE,
  output logic [CODE_W-1:0]      O_RIGHT_CODE,
  output logic                   O_MOD_STROBE,
  output logic                   O_MIDSCALE,
  output logic                   O_OUTPUT_VALID
);
  localparam int ZC_W = $clog2(ZERO_COUNT + 1);

  // bit clock domain
  logic               wl_s1_reg, wl_s2_reg, zen_s1_reg, zen_s2_reg;
  logic               lrck_b_reg, lrck_b_next, bit_reg, bit_next;
  logic [SMP_W-1:0]   shift_reg, shift_next, word;
  logic [SMP_W-1:0]   left_hold_reg, left_hold_next;
  dsd_pair_type       pair_reg, pair_next;
  logic               tgl_reg, tgl_next, zero_b_reg, zero_b_next;
  logic [ZC_W-1:0]    same_reg, same_next, stop_reg, stop_next;

  // system clock domain
  logic               lr_s1_reg, lr_s2_reg, lr_s3_reg;
  logic               tg_s1_reg, tg_s2_reg, tg_s3_reg;
  logic               zr_s1_reg, zr_s2_reg, r3_s1_reg, r3_s2_reg;
  logic [DIV_W-1:0]   div_reg, div_next, div_last;
  logic [ITK_W-1:0]   itk_reg, itk_next, itk_last;
  logic [2:0]         islot_reg, islot_next;
  logic               sample_tick, interp_tick, itp_load, mod_tick;
  logic               pend_reg, pend_next, lr_rise, force_mid;
  dsd_pair_type       pend_data_reg, pend_data_next;
  logic               fifo_wr_ready, fifo_rd_valid;
  logic [2*SMP_W-1:0] fifo_rd_data;
  dsd_pair_type       dl_reg [DL_LEN];
  dsd_pair_type       dl_next [DL_LEN];
  dsd_pair_type       cur_reg, cur_next, prev_reg, prev_next;
  dsd_pair_type       x_reg, x_next;
  logic [2:0]         ph_reg, ph_next;
  dsd_loop_type       loop_reg [2];
  dsd_loop_type       loop_next [2];
  logic [CODE_W-1:0]  code_reg [2];
  logic [CODE_W-1:0]  code_next [2];
  logic signed [SMP_W-1:0] xs [2];
  dsd_mod_type        step [2];
  dsd_state_type      state_reg, state_next;
  logic [LRCK_CNT_W-1:0] lr_cnt_reg, lr_cnt_next;
  logic [PER_W-1:0]   per_reg, per_next, per_prev_reg, per_prev_next;
  logic               rate_jump, strobe_reg, mid_reg, valid_reg;

  function automatic logic signed [ACC_W+1:0] ext(
    input logic signed [ACC_W-1:0] v);
    return (ACC_W+2)'(v);
  endfunction

  function automatic logic signed [ACC_W-1:0] sat(
    input logic signed [ACC_W+1:0] v);
    if (v > ext(ACC_MAX))
      return ACC_MAX;
    if (v < -ext(ACC_MAX))
      return -ACC_MAX;
    return ACC_W'(v);
  endfunction

  function automatic logic signed [SMP_W-1:0] lerp(
    input logic signed [SMP_W-1:0] a,
    input logic signed [SMP_W-1:0] b,
    input logic [2:0]              ph);
    logic signed [SMP_W+4:0] d;
    d = ((SMP_W+5)'(b) - (SMP_W+5)'(a)) * $signed({1'b0, ph});
    return a + SMP_W'(d >>> INTERP_SH);
  endfunction

  // one modulator step; the loop state is read before it is updated,
  // which keeps the quantiser out of a combinational loop
  function automatic dsd_mod_type mod_step(
    input dsd_loop_type            s,
    input logic signed [SMP_W-1:0] x,
    input logic [CODE_W-1:0]       c);
    dsd_mod_type             r;
    logic signed [ACC_W-1:0] fb;
    logic signed [ACC_W+1:0] y;
    fb = (ACC_W'($signed({1'b0, c})) - ACC_W'(CODE_MID)) <<< LVL_SH;
    r.loop.i1 = sat(ext(s.i1) + ext(ACC_W'(x)) - ext(fb));
    r.loop.i2 = sat(ext(s.i2) + (ext(s.i1) >>> INT_SH)
                    - (ext(fb) >>> COMP_SH2));
    r.loop.i3 = sat(ext(s.i3) + (ext(s.i2) >>> INT_SH)
                    - (ext(fb) >>> COMP_SH3));
    r.loop.i4 = sat(ext(s.i4) + (ext(s.i3) >>> INT_SH)
                    - (ext(fb) >>> COMP_SH4));
    y = (ext(s.i1) >>> FEED_SH1) + (ext(s.i2) >>> FEED_SH2)
      + (ext(s.i3) >>> FEED_SH3) + (ext(s.i4) >>> FEED_SH4);
    if (y < -(ACC_W+2)'(Q_HI))
      r.code = 3'h0;
    else if (y < -(ACC_W+2)'(Q_LO))
      r.code = 3'h1;
    else if (y < (ACC_W+2)'(Q_LO))
      r.code = 3'h2;
    else if (y < (ACC_W+2)'(Q_HI))
      r.code = 3'h3;
    else
      r.code = CODE_MAX;
    return r;
  endfunction

  // bit clock side: right-justified words, msb first
  always_comb
  begin
    lrck_b_next    = I_SAMPLE_RATE_CLOCK_IN;
    bit_next       = I_SERIAL_DATA_IN;
    shift_next     = {shift_reg[SMP_W-2:0], I_SERIAL_DATA_IN};
    word = wl_s2_reg ? shift_reg : {shift_reg[IN16_W-1:0], PAD_W'(0)};
    left_hold_next = left_hold_reg;
    pair_next      = pair_reg;
    tgl_next       = tgl_reg;
    if (lrck_b_next != lrck_b_reg)
    begin
      if (lrck_b_reg)
        left_hold_next = word;
      else
      begin
        pair_next = '{left: left_hold_reg, right: word};
        tgl_next  = !tgl_reg;
      end
    end
    same_next = (I_SERIAL_DATA_IN == bit_reg && same_reg != ZC_W'(ZERO_COUNT))
              ? same_reg + 1'b1 : same_reg;
    if (I_SERIAL_DATA_IN != bit_reg)
      same_next = '0;
    stop_next = (lrck_b_next != lrck_b_reg) ? '0
              : (stop_reg != ZC_W'(ZERO_COUNT)) ? stop_reg + 1'b1
              : stop_reg;
    zero_b_next = (zen_s2_reg && same_reg == ZC_W'(ZERO_COUNT))
               || stop_reg == ZC_W'(ZERO_COUNT);
  end

  always_ff @(posedge I_SERIAL_BIT_CLOCK_IN or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      {wl_s1_reg, wl_s2_reg, zen_s1_reg, zen_s2_reg} <= 4'h3;
      {lrck_b_reg, bit_reg, tgl_reg, zero_b_reg}     <= 4'h0;
      shift_reg     <= '0;
      left_hold_reg <= '0;
      pair_reg      <= '0;
      same_reg      <= '0;
      stop_reg      <= '0;
    end
    else
    begin
      wl_s1_reg     <= I_WORD_LENGTH_SELECT;
      wl_s2_reg     <= wl_s1_reg;
      zen_s1_reg    <= I_ZERO_DETECT_ENABLE;
      zen_s2_reg    <= zen_s1_reg;
      lrck_b_reg    <= lrck_b_next;
      bit_reg       <= bit_next;
      shift_reg     <= shift_next;
      left_hold_reg <= left_hold_next;
      pair_reg      <= pair_next;
      tgl_reg       <= tgl_next;
      same_reg      <= same_next;
      stop_reg      <= stop_next;
      zero_b_reg    <= zero_b_next;
    end
  end

  // system clock side: rate timing, transfer and datapath
  assign sample_tick = (div_reg == '0);
  assign interp_tick = (itk_reg == '0);
  assign itp_load    = interp_tick && islot_reg == 3'(LAT_FRAC);
  assign mod_tick    = ((div_reg & DIV_W'(MOD_DIV - 1)) == '0);
  assign lr_rise     = lr_s2_reg && !lr_s3_reg;
  assign force_mid   = zr_s2_reg || state_reg == ST_WAIT_POR;
  assign xs[0]       = x_reg.left;
  assign xs[1]       = x_reg.right;

  always_comb
  begin
    div_last = r3_s2_reg ? DIV_W'(RATIO_384 - 1) : DIV_W'(RATIO_256 - 1);
    itk_last = r3_s2_reg ? ITK_W'(RATIO_384 / OSR_INTERP - 1)
                         : ITK_W'(RATIO_256 / OSR_INTERP - 1);
    div_next   = (div_reg >= div_last) ? '0 : div_reg + 1'b1;
    itk_next   = (div_reg >= div_last || itk_reg >= itk_last)
               ? '0 : itk_reg + 1'b1;
    islot_next = (div_reg >= div_last) ? '0
               : (itk_reg >= itk_last) ? islot_reg + 1'b1 : islot_reg;
    // a held capture stalls until the fifo has room; a newer one replaces it
    pend_next      = (pend_reg && fifo_wr_ready) ? 1'b0 : pend_reg;
    pend_data_next = pend_data_reg;
    if (tg_s2_reg != tg_s3_reg)
    begin
      pend_next      = 1'b1;
      pend_data_next = pair_reg;
    end
    dl_next   = dl_reg;
    cur_next  = cur_reg;
    prev_next = prev_reg;
    ph_next   = ph_reg;
    x_next    = x_reg;
    if (sample_tick)
    begin
      dl_next[0] = fifo_rd_valid ? dsd_pair_type'(fifo_rd_data) : dl_reg[0];
      for (int i = 1; i < DL_LEN; i++)
        dl_next[i] = dl_reg[i-1];
    end
    if (interp_tick)
    begin
      x_next.left  = lerp(prev_reg.left, cur_reg.left, ph_reg);
      x_next.right = lerp(prev_reg.right, cur_reg.right, ph_reg);
      ph_next      = ph_reg + 1'b1;
      if (itp_load)
      begin
        prev_next = cur_reg;
        cur_next  = dl_reg[DL_LEN-1];
        ph_next   = '0;
      end
    end
    for (int c = 0; c < 2; c++)
    begin
      step[c]      = mod_step(loop_reg[c], xs[c], code_reg[c]);
      loop_next[c] = loop_reg[c];
      code_next[c] = code_reg[c];
      if (force_mid)
      begin
        loop_next[c] = '0;
        code_next[c] = CODE_MID;
      end
      else if (mod_tick)
      begin
        loop_next[c] = step[c].loop;
        code_next[c] = step[c].code;
      end
    end
  end

  // sample clock watch: power-up wait and rate-change settling
  always_comb
  begin
    per_next      = lr_rise ? '0 : (&per_reg ? per_reg : per_reg + 1'b1);
    per_prev_next = lr_rise ? per_reg : per_prev_reg;
    rate_jump     = lr_rise && per_prev_reg != '0
                 && (per_reg > per_prev_reg + PER_W'(RATE_TOL)
                  || per_prev_reg > per_reg + PER_W'(RATE_TOL));
    state_next  = state_reg;
    lr_cnt_next = lr_rise ? lr_cnt_reg + 1'b1 : lr_cnt_reg;
    case (state_reg)
      ST_WAIT_POR:
        if (lr_rise && lr_cnt_reg == LRCK_CNT_W'(POR_LRCK - 1))
        begin
          state_next  = ST_RUN;
          lr_cnt_next = '0;
        end
      ST_RUN:
        if (rate_jump)
        begin
          state_next  = ST_SETTLE;
          lr_cnt_next = '0;
        end
      ST_SETTLE:
        if (rate_jump)
          lr_cnt_next = '0;
        else if (lr_rise && lr_cnt_reg == LRCK_CNT_W'(INVALID_LRCK - 1))
        begin
          state_next  = ST_RUN;
          lr_cnt_next = '0;
        end
      default:
        state_next = ST_WAIT_POR;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      {lr_s1_reg, lr_s2_reg, lr_s3_reg} <= 3'h0;
      {tg_s1_reg, tg_s2_reg, tg_s3_reg} <= 3'h0;
      {zr_s1_reg, zr_s2_reg, r3_s1_reg, r3_s2_reg} <= 4'h0;
      div_reg <= '0;
      itk_reg <= '0;
      islot_reg <= '0;
      pend_reg <= 1'b0;
      pend_data_reg <= '0;
      dl_reg <= '{default: '0};
      cur_reg <= '0;
      prev_reg <= '0;
      x_reg <= '0;
      ph_reg <= '0;
      loop_reg <= '{default: '0};
      code_reg <= '{default: CODE_MID};
      state_reg <= ST_WAIT_POR;
      lr_cnt_reg <= '0;
      per_reg <= '0;
      per_prev_reg <= '0;
      {strobe_reg, mid_reg, valid_reg} <= 3'h2;
    end
    else
    begin
      lr_s1_reg <= I_SAMPLE_RATE_CLOCK_IN;
      lr_s2_reg <= lr_s1_reg;
      lr_s3_reg <= lr_s2_reg;
      tg_s1_reg <= tgl_reg;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
      zr_s1_reg <= zero_b_reg;
      zr_s2_reg <= zr_s1_reg;
      r3_s1_reg <= I_RATIO_384;
      r3_s2_reg <= r3_s1_reg;
      div_reg <= div_next;
      itk_reg <= itk_next;
      islot_reg <= islot_next;
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      dl_reg <= dl_next;
      cur_reg <= cur_next;
      prev_reg <= prev_next;
      x_reg <= x_next;
      ph_reg <= ph_next;
      loop_reg <= loop_next;
      code_reg <= code_next;
      state_reg <= state_next;
      lr_cnt_reg <= lr_cnt_next;
      per_reg <= per_next;
      per_prev_reg <= per_prev_next;
      strobe_reg <= mod_tick;
      mid_reg <= (state_next == ST_WAIT_POR) || zr_s2_reg;
      valid_reg <= (state_next == ST_RUN) && !zr_s2_reg;
    end
  end

  dsd_fifo #(.WIDTH(2 * SMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk      (I_MCLK),
    .i_reset_n  (I_RESET_N),
    .i_wr_valid (pend_reg),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (pend_data_reg),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (sample_tick),
    .o_rd_data  (fifo_rd_data)
  );

  assign O_LEFT_CODE    = code_reg[0];
  assign O_RIGHT_CODE   = code_reg[1];
  assign O_MOD_STROBE   = strobe_reg;
  assign O_MIDSCALE     = mid_reg;
  assign O_OUTPUT_VALID = valid_reg;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);

  sequence mod_gap_s;
    !mod_tick [*7] ##1 mod_tick;
  endsequence

  code_range_a: assert property (code_reg[0] <= CODE_MAX
    && code_reg[1] <= CODE_MAX) else $error("code out of range");
  mod_rate_a: assert property (mod_tick |=> mod_gap_s)
    else $error("modulator step spacing wrong");
  lat_frac_256_a: assert property (sample_tick && !r3_s2_reg
    && $stable(r3_s2_reg) |-> ##160 itp_load)
    else $error("fractional latency wrong at 256fs");
  lat_frac_384_a: assert property (sample_tick && r3_s2_reg
    && $stable(r3_s2_reg) |-> ##240 itp_load)
    else $error("fractional latency wrong at 384fs");
  midscale_force_a: assert property (zr_s2_reg |=> O_MIDSCALE
    && O_LEFT_CODE == CODE_MID && O_RIGHT_CODE == CODE_MID)
    else $error("zero detect did not force midscale");
  por_release_a: assert property (state_reg == ST_WAIT_POR
    && lr_rise && lr_cnt_reg == LRCK_CNT_W'(POR_LRCK - 1)
    |=> state_reg == ST_RUN && O_MIDSCALE == $past(zr_s2_reg))
    else $error("power-up reset not released after 64 periods");
  settle_hold_a: assert property (rate_jump |=> !O_OUTPUT_VALID [*8])
    else $error("output valid during rate change window");
  pad_low_a: assert property (@(posedge I_SERIAL_BIT_CLOCK_IN)
    disable iff (!I_RESET_N)
    $changed(tgl_reg) && !wl_s2_reg && $stable(wl_s2_reg)
    |-> pair_reg.right[PAD_W-1:0] == '0)
    else $error("16-bit word not padded with low zeros");
  word20_a: assert property (@(posedge I_SERIAL_BIT_CLOCK_IN)
    disable iff (!I_RESET_N)
    $changed(tgl_reg) && wl_s2_reg && $stable(wl_s2_reg)
    |-> pair_reg.right == $past(shift_reg))
    else $error("20-bit word not taken whole");
  zero_det_a: assert property (@(posedge I_SERIAL_BIT_CLOCK_IN)
    disable iff (!I_RESET_N)
    zen_s2_reg && same_reg == ZC_W'(ZERO_COUNT) |=> zero_b_reg)
    else $error("zero detect missed constant data");
endmodule // dsd_dac_core

//--- dsd_pkg.sv
// constants, field layouts and carrier types of the delta-sigma dac core
// assumes: included first; every other design file imports dsd_pkg::*
package dsd_pkg;
  localparam int SMP_W      = 20;
  localparam int IN16_W     = 16;
  localparam int PAD_W      = 4;
  localparam int ACC_W      = 28;
  localparam int CODE_W     = 3;
  localparam logic [CODE_W-1:0] CODE_MID = 3'h2;
  localparam logic [CODE_W-1:0] CODE_MAX = 3'h4;
  // system clock per sample and its derived rates
  localparam int RATIO_256  = 256;
  localparam int RATIO_384  = 384;
  localparam int DIV_W      = 9;
  localparam int OSR_INTERP = 8;
  localparam int INTERP_SH  = 3;
  localparam int ITK_W      = 6;
  localparam int MOD_DIV    = 8;
  // 22.625 sample periods = 22 whole periods + 5/8 of one
  localparam int LAT_WHOLE  = 22;
  localparam int LAT_FRAC   = 5;
  localparam int DL_LEN     = LAT_WHOLE - 1;
  localparam int ZERO_BCLK  = 65536;
  localparam int POR_LRCK   = 64;
  localparam int INVALID_EXTRA = 2;
  // latency rounded up to whole periods, then two more
  localparam int INVALID_LRCK  = LAT_WHOLE + 1 + INVALID_EXTRA;
  localparam int LRCK_CNT_W = 7;
  localparam int PER_W      = 16;
  localparam int RATE_TOL   = 4;
  localparam int FIFO_DEPTH = 8;
  // loop filter: feed shifts set the shape, comp shifts stabilise
  localparam int FEED_SH1   = 1;
  localparam int FEED_SH2   = 2;
  localparam int FEED_SH3   = 4;
  localparam int FEED_SH4   = 6;
  localparam int COMP_SH2   = 1;
  localparam int COMP_SH3   = 3;
  localparam int COMP_SH4   = 5;
  localparam int INT_SH     = 1;
  localparam int LVL_SH     = 18;
  localparam int Q_LO       = 1 << (LVL_SH - 1);
  localparam int Q_HI       = 3 * Q_LO;
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};

  typedef struct packed {
    logic signed [SMP_W-1:0] left;
    logic signed [SMP_W-1:0] right;
  } dsd_pair_type;

  typedef struct packed {
    logic signed [ACC_W-1:0] i1;
    logic signed [ACC_W-1:0] i2;
    logic signed [ACC_W-1:0] i3;
    logic signed [ACC_W-1:0] i4;
  } dsd_loop_type;

  typedef struct packed {
    dsd_loop_type            loop;
    logic [CODE_W-1:0]       code;
  } dsd_mod_type;

  typedef enum logic [1:0] {ST_WAIT_POR, ST_RUN, ST_SETTLE} dsd_state_type;
endpackage

//--- dsd_fifo.sv
// sample-pair fifo between the serial capture and the sample clock
// assumes: one clock; writer and reader both honour valid/ready
module dsd_fifo
  import dsd_pkg::*;
#(
  parameter int WIDTH = 40,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             do_wr;
  logic             do_rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign o_rd_data  = mem_reg[rd_ptr_reg];
  assign do_wr      = i_wr_valid && o_wr_ready;
  assign do_rd      = o_rd_valid && i_rd_ready;

  always_comb
  begin
    wr_ptr_next = do_wr ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = do_rd ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    case ({do_wr, do_rd})
      2'b10:   count_next = count_reg + 1'b1;
      2'b01:   count_next = count_reg - 1'b1;
      default: count_next = count_reg;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage needs no reset; o_rd_data is only taken while count_reg is nonzero
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg] <= i_wr_data;
  end
endmodule // dsd_fifo

//--- dsd_src_model.sv
// audio source model: bit clock, sample clock and serial data
// assumes: bit clock locked to 256 or 384 system clocks per sample
module dsd_src_model
  import dsd_pkg::*;
(
  input  wire logic             i_r384,
  input  wire logic             i_w20,
  input  wire logic             i_hold,
  input  wire logic             i_stop,
  input  wire logic [SMP_W-1:0] i_smp,
  output logic                  o_bclk,
  output logic                  o_lrck,
  output logic                  o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int half;
  int n;

  // odd offset keeps the bit clock out of phase with the system clock
  initial
  begin
    cnt = 0;
    o_bclk = 1'b0;
    o_lrck = 1'b1;
    o_data = 1'b0;
    #13;
    forever #40 o_bclk = ~o_bclk;
  end

  always @(negedge o_bclk)
  begin
    half = i_r384 ? 96 : 64;
    if (cnt >= half)
      cnt = 0;
    n = half - 1 - cnt;
    if (cnt == 0 && !i_stop)
      o_lrck <= ~o_lrck;
    // right justified: lsb is sampled before the clock toggles
    if (i_hold)
      o_data <= 1'b0;
    else if (n < (i_w20 ? 20 : 16))
      o_data <= i_smp[n];
    else
      o_data <= ~o_data;
    if (!i_stop)
      cnt = (n == 0) ? 0 : cnt + 1;
  end
endmodule // dsd_src_model

//--- tb_delta_sigma_dac_core.sv
// self-checking bench of the dac core driven by the source model
// assumes: zero detect count cut to 128 bit clocks, above the 96-clock
// half frame at 384fs; 25 MHz system clock
module tb_delta_sigma_dac_core import dsd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              r384 = 1'b0;
  logic              w20 = 1'b1;
  logic              hold = 1'b0;
  logic              stop = 1'b0;
  logic              zen = 1'b1;
  logic [SMP_W-1:0]  smp = '0;
  logic              bclk, lrck, sdata, strobe, mid, valid;
  logic [CODE_W-1:0] lcode, rcode;
  logic [31:0]       s, k, s20;
  int                failures = 0;
  int                cmp_count = 0;

  dsd_dac_core #(.ZERO_COUNT(128)) u_dsd_dac_core (
    .I_MCLK(mclk), .I_RESET_N(rst_n), .I_SERIAL_BIT_CLOCK_IN(bclk),
    .I_SAMPLE_RATE_CLOCK_IN(lrck), .I_SERIAL_DATA_IN(sdata),
    .I_WORD_LENGTH_SELECT(w20), .I_ZERO_DETECT_ENABLE(zen),
    .I_RATIO_384(r384), .O_LEFT_CODE(lcode), .O_RIGHT_CODE(rcode),
    .O_MOD_STROBE(strobe), .O_MIDSCALE(mid), .O_OUTPUT_VALID(valid));
  dsd_src_model u_dsd_src_model (.i_r384(r384), .i_w20(w20),
    .i_hold(hold), .i_stop(stop), .i_smp(smp), .o_bclk(bclk),
    .o_lrck(lrck), .o_data(sdata));

  initial
  begin
    forever #20 mclk = ~mclk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
                         input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic per(input int p);
    repeat (p * (r384 ? 384 : 256)) @(negedge mclk);
  endtask

  // steps and code total of both channels over one sample period
  task automatic sum_codes();
    s = 0;
    k = 0;
    repeat (r384 ? 384 : 256)
    begin
      @(negedge mclk);
      if (strobe === 1'b1)
      begin
        k = k + 1;
        s = s + 32'(lcode) + 32'(rcode);
        chk_rng(32'(lcode), 0, 4);
      end
    end
  endtask

  task automatic wait_mid();
    for (int i = 0; i < 400 && mid !== 1'b1; i++) @(negedge mclk);
  endtask

  task automatic t_power_up();
    repeat (20) @(negedge mclk);
    chk_val({mid, valid, strobe, lcode}, 32'h22);
    rst_n = 1'b1;
    per(60);
    chk_val(mid, 1'b1);
    per(8);
    chk_val(mid, 1'b0);
    sum_codes();
    chk_val(k, 32'h20);
    chk_rng(s, 120, 136);
  endtask

  // a 16-bit half-scale word must land like the 20-bit one
  task automatic t_words();
    smp = 20'h40000;
    per(18);
    sum_codes();
    chk_rng(s, 116, 140);
    per(10);
    sum_codes();
    s20 = s;
    chk_rng(s20, 144, 256);
    w20 = 1'b0;
    smp = 20'h04000;
    per(28);
    sum_codes();
    chk_rng(s, s20 - 8, s20 + 8);
    chk_val(valid, 1'b1);
  endtask

  task automatic t_rate();
    // switch after the fractional load of this period, so no load
    // window straddles the ratio change
    repeat (192) @(negedge mclk);
    r384 = 1'b1;
    per(2);
    chk_val(valid, 1'b0);
    per(21);
    chk_val(valid, 1'b0);
    per(7);
    chk_val(valid, 1'b1);
    sum_codes();
    chk_val(k, 32'h30);
  endtask

  task automatic t_zero();
    zen = 1'b0;
    hold = 1'b1;
    repeat (400) @(negedge mclk);
    chk_val(mid, 1'b0);
    hold = 1'b0;
    per(1);
    zen = 1'b1;
    hold = 1'b1;
    repeat (100) @(negedge mclk);
    chk_val(mid, 1'b0);
    wait_mid();
    chk_val({mid, lcode, rcode}, 32'h52);
    hold = 1'b0;
    repeat (60) @(negedge mclk);
    chk_val(mid, 1'b0);
    zen = 1'b0;
    stop = 1'b1;
    wait_mid();
    chk_val({mid, lcode, rcode}, 32'h52);
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    t_power_up();
    t_words();
    t_rate();
    t_zero();
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
endmodule // tb_delta_sigma_dac_core
